/* File: charge_time_edge_control.sv */
/*
 charge_time_edge_control: control word, edge source selection, status flags and analog
 control outputs of the charge-time measurement unit, behind an AXI4-Lite slave.
 assumes: source inputs arrive asynchronously; capture, compare and timer events and
 idleMode come from logic on clk.
*/
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
// Operation
// - edge2 flag shows edge2 seen, software writable
// - edge1 flag shows edge1 seen, software writable
// - edge2 mode bit: edge or level sensitive
// - edge2 polarity bit: rising or falling
// - edge2 codes f..c: comparators, bus clock
// - edge2 codes b..0: captures, pins, compare, timer
// - edge1 code 0000 selects timer1 event
// - bits 17 and 16 read zero
// - enable bit turns the unit on
// - idle-stop halts unit during idle mode
// - delay generation enable bit
// - edge pass bit blocks or passes edges
// - order bit: edge2 only after edge1
// - ground switch bit grounds current source
// - trigger output enable bit
// - signed six-bit current trim field
// - two-bit current range select
// - edge1 mode and polarity bits
// - edge1 source field: codes c..a captures, 9..4 pins, others as in edge2 field
// - clear, set, invert aliases at 4, 8, c
`timescale 1ns/1ps
module charge_time_edge_control #(
    parameter int PinCount = 13
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // axi4-lite write address
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // axi4-lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // asynchronous edge sources
    input  wire logic [3:1]          comparatorOut,
    input  wire logic [PinCount:1]   edgePin,
    // synchronous edge sources and idle mode
    input  wire logic [3:1]          captureEvent,
    input  wire logic                compareEvent1,
    input  wire logic                timer1Event,
    input  wire logic                idleMode,
    // analog and trigger controls
    output logic                     unitActive,
    output logic                     delayGenActive,
    output logic                     sourceGround,
    output logic                     triggerOut,
    output logic [5:0]               currentTrim,
    output logic [1:0]               currentRange
);
    localparam int AsyncW = 3 + PinCount;

    // reset synchroniser
    logic rstMeta;
    logic rstSyncN;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // two-stage synchronisers for comparators and pins
    logic [AsyncW-1:0] asyncIn;
    logic [AsyncW-1:0] syncMeta;
    logic [AsyncW-1:0] syncReg;
    assign asyncIn = {comparatorOut, edgePin};
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            syncMeta <= '0;
            syncReg  <= '0;
        end else begin
            syncMeta <= asyncIn;
            syncReg  <= syncMeta;
        end
    end
    logic [3:1]          compSync;
    logic [PinCount:1]   pinSync;
    assign compSync = syncReg[AsyncW-1:PinCount];
    assign pinSync  = syncReg[PinCount-1:0];

    // control register
    logic [31:0] ctrlReg;
    logic [31:0] ctrlNext;

    logic clkPhaseReg;
    // source mux; channel 2 takes bus clock at code c and a pin block offset by 6
    function automatic logic pickSource(input logic [3:0] code, input logic second);
        logic r;
        r = 1'b0;
        case (code)
            4'hf: r = compSync[3];
            4'he: r = compSync[2];
            4'hd: r = compSync[1];
            4'hc: r = second ? clkPhaseReg : captureEvent[3];
            4'hb: r = second ? captureEvent[3] : captureEvent[2];
            4'ha: r = second ? captureEvent[2] : captureEvent[1];
            4'h9: r = second ? captureEvent[1] : pinSync[8];
            4'h8: r = second ? pinSync[13] : pinSync[7];
            4'h7: r = second ? pinSync[12] : pinSync[6];
            4'h6: r = second ? pinSync[11] : pinSync[5];
            4'h5: r = second ? pinSync[10] : pinSync[4];
            4'h4: r = second ? pinSync[9] : pinSync[3];
            charge_time_pkg::SrcPin1:     r = pinSync[1];
            charge_time_pkg::SrcPin2:     r = pinSync[2];
            charge_time_pkg::SrcCompare1: r = compareEvent1;
            charge_time_pkg::SrcTimer1:   r = timer1Event;
            default:                      r = 1'b0;
        endcase
        return r;
    endfunction

    // bus clock as a source: a toggling level at half rate, edge seen every other cycle
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            clkPhaseReg <= 1'b0;
        end else begin
            clkPhaseReg <= ~clkPhaseReg;
        end
    end

    edge_if ch1 ();
    edge_if ch2 ();
    assign ch1.srcLevel = pickSource(ctrlReg[charge_time_pkg::Edge1SelLsb +: 4], 1'b0);
    assign ch2.srcLevel = pickSource(ctrlReg[charge_time_pkg::Edge2SelLsb +: 4], 1'b1);
    assign ch1.edgeMode = ctrlReg[charge_time_pkg::Edge1ModeBit];
    assign ch1.polarity = ctrlReg[charge_time_pkg::Edge1PolBit];
    assign ch2.edgeMode = ctrlReg[charge_time_pkg::Edge2ModeBit];
    assign ch2.polarity = ctrlReg[charge_time_pkg::Edge2PolBit];

    edge_qualifier det1 (
        .clk      (clk),
        .rstSyncN (rstSyncN),
        .ch       (ch1.det)
    );
    edge_qualifier det2 (
        .clk      (clk),
        .rstSyncN (rstSyncN),
        .ch       (ch2.det)
    );

    // run state and flag setting
    logic running;
    logic edgesOpen;
    logic set1;
    logic set2;
    assign running   = ctrlReg[charge_time_pkg::EnableBit] &
                       ~(ctrlReg[charge_time_pkg::IdleStopBit] & idleMode);
    assign edgesOpen = running & ctrlReg[charge_time_pkg::EdgePassBit];
    assign set1      = edgesOpen & ch1.event_;
    // with ordering on, edge2 counts only once edge1 is already recorded
    assign set2      = edgesOpen & ch2.event_ &
                       (~ctrlReg[charge_time_pkg::EdgeOrderBit] | ctrlReg[charge_time_pkg::Edge1StatBit]);

    // axi write channel: address and data latched independently
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0]  wStrbReg;
    logic        doWrite;
    logic [31:0] strbMask;
    logic [31:0] wBits;
    logic        wHit;
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
    assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
    assign strbMask      = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
    assign wBits         = wDataReg & strbMask & charge_time_pkg::ImplMask;
    assign wHit          = (awAddrReg == charge_time_pkg::OffControl) | (awAddrReg == charge_time_pkg::OffClear) |
                           (awAddrReg == charge_time_pkg::OffSet) | (awAddrReg == charge_time_pkg::OffInvert);

    // software update first, then hardware flag sets win over any clear in the same cycle
    logic [31:0] swNext;
    always_comb begin
        swNext = ctrlReg;
        if (doWrite) begin
            case (awAddrReg)
                charge_time_pkg::OffControl: swNext = (ctrlReg & ~(strbMask & charge_time_pkg::ImplMask)) | wBits;
                charge_time_pkg::OffClear:   swNext = ctrlReg & ~wBits;
                charge_time_pkg::OffSet:     swNext = ctrlReg | wBits;
                charge_time_pkg::OffInvert:  swNext = ctrlReg ^ wBits;
                default:                     swNext = ctrlReg;
            endcase
        end
        ctrlNext = swNext;
        ctrlNext[charge_time_pkg::Edge1StatBit] = swNext[charge_time_pkg::Edge1StatBit] | set1;
        ctrlNext[charge_time_pkg::Edge2StatBit] = swNext[charge_time_pkg::Edge2StatBit] | set2;
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ctrlReg <= charge_time_pkg::ControlReset;
        end else begin
            ctrlReg <= ctrlNext;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddrReg    <= 8'h00;
            wDataReg     <= 32'h00000000;
            wStrbReg     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= charge_time_pkg::RespOkay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld    <= 1'b1;
                awAddrReg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld    <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wHit ? charge_time_pkg::RespOkay : charge_time_pkg::RespSlvErr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel; alias offsets read back the control word
    logic [7:0]  rAddr;
    logic [31:0] statusWord;
    logic        rHit;
    logic [31:0] rWord;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rAddr         = {s_axi_araddr[7:2], 2'b00};
    assign statusWord    = {28'h0000000, set2, set1, edgesOpen, running};
    assign rHit          = (rAddr == charge_time_pkg::OffStatus) | (rAddr <= charge_time_pkg::OffInvert);
    assign rWord         = (rAddr == charge_time_pkg::OffStatus) ? statusWord :
                           (rHit ? (ctrlReg & charge_time_pkg::ImplMask) : 32'h00000000);

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= charge_time_pkg::RespOkay;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rWord;
                s_axi_rresp  <= rHit ? charge_time_pkg::RespOkay : charge_time_pkg::RespSlvErr;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // analog controls follow the register; trim and range pass raw to the analog trim decoder
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            unitActive     <= 1'b0;
            delayGenActive <= 1'b0;
            sourceGround   <= 1'b0;
            triggerOut     <= 1'b0;
            currentTrim    <= 6'h00;
            currentRange   <= 2'h0;
        end else begin
            unitActive     <= running;
            delayGenActive <= running & ctrlReg[charge_time_pkg::DelayGenBit];
            sourceGround   <= ctrlReg[charge_time_pkg::GroundBit];
            // trigger pulses on an edge2 event while enabled
            triggerOut     <= ctrlReg[charge_time_pkg::TriggerBit] & set2;
            currentTrim    <= ctrlReg[charge_time_pkg::TrimLsb +: 6];
            currentRange   <= ctrlReg[charge_time_pkg::RangeLsb +: 2];
        end
    end
endmodule

/* File: charge_time_pkg.sv */
/*
 charge_time_pkg: register offsets, field positions, reset values and source codes of the
 charge-time edge control block.
 assumes: a 32-bit AXI4-Lite register bus, word aligned.
*/
package charge_time_pkg;
    // byte offsets: base word, its clear, set and invert aliases, and the status word
    localparam logic [7:0] OffControl = 8'h00;
    localparam logic [7:0] OffClear   = 8'h04;
    localparam logic [7:0] OffSet     = 8'h08;
    localparam logic [7:0] OffInvert  = 8'h0c;
    localparam logic [7:0] OffStatus  = 8'h10;

    // field positions
    localparam int Edge1ModeBit   = 31;
    localparam int Edge1PolBit    = 30;
    localparam int Edge1SelLsb    = 26;
    localparam int Edge2StatBit   = 25;
    localparam int Edge1StatBit   = 24;
    localparam int Edge2ModeBit   = 23;
    localparam int Edge2PolBit    = 22;
    localparam int Edge2SelLsb    = 18;
    localparam int EnableBit      = 15;
    localparam int IdleStopBit    = 13;
    localparam int DelayGenBit    = 12;
    localparam int EdgePassBit    = 11;
    localparam int EdgeOrderBit   = 10;
    localparam int GroundBit      = 9;
    localparam int TriggerBit     = 8;
    localparam int TrimLsb        = 2;
    localparam int RangeLsb       = 0;

    // implemented bits: 17, 16 and 14 read zero
    localparam logic [31:0] ImplMask     = 32'hfffcbfff;
    localparam logic [31:0] ControlReset = 32'h00000000;

    // source codes shared by both edge selectors
    localparam logic [3:0] SrcTimer1   = 4'h0;
    localparam logic [3:0] SrcCompare1 = 4'h1;
    localparam logic [3:0] SrcPin2     = 4'h2;
    localparam logic [3:0] SrcPin1     = 4'h3;
    localparam logic [3:0] SrcComp2    = 4'he;

    localparam logic [1:0] RespOkay   = 2'b00;
    localparam logic [1:0] RespSlvErr = 2'b10;
endpackage

/* File: edge_if.sv */
/*
 edge_if: carries one edge channel's settings and result between the control block and
 an edge detector.
 assumes: one clock domain; source already synchronised.
*/
`timescale 1ns/1ps
interface edge_if;
    logic srcLevel;
    logic edgeMode;
    logic polarity;
    logic event_;
    modport ctrl (output srcLevel, output edgeMode, output polarity, input event_);
    modport det  (input srcLevel, input edgeMode, input polarity, output event_);
endinterface

/* File: edge_qualifier.sv */
/*
 edge_qualifier: turns a selected, synchronised source level into an event, one cycle long in edge mode,
 edge- or level-sensitive, with selectable polarity.
 assumes: srcLevel is already on clk; rstSyncN is the synchronised active-low reset.
*/
`timescale 1ns/1ps
module edge_qualifier (
    // clock and reset
    input wire logic clk,
    input wire logic rstSyncN,
    // edge channel
    edge_if.det      ch
);
    logic prevReg;
    logic activeNow;
    logic activePrev;

    assign activeNow  = ch.polarity ? ch.srcLevel : ~ch.srcLevel;
    assign activePrev = ch.polarity ? prevReg : ~prevReg;
    // edge mode fires on the transition into the active level, level mode whenever active
    assign ch.event_  = ch.edgeMode ? (activeNow & ~activePrev) : activeNow;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prevReg <= 1'b0;
        end else begin
            prevReg <= ch.srcLevel;
        end
    end
endmodule

/* File: charge_time_edge_control_properties.sv */
/*
 charge_time_edge_control_properties: bus and output checks on the top ports.
 assumes: bound to charge_time_edge_control; one clock; bench keeps wstrb at 4'hf.
*/
`timescale 1ns/1ps
module charge_time_edge_control_properties #(
    parameter int PinCount = 13
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // status and outputs
    input wire logic        idleMode,
    input wire logic        unitActive,
    input wire logic        delayGenActive,
    input wire logic        sourceGround,
    input wire logic        triggerOut,
    input wire logic [5:0]  currentTrim,
    input wire logic [1:0]  currentRange
);
    logic [7:0]  awCap;
    logic [7:0]  arCap;
    logic [31:0] wCap;
    logic [3:0]  sCap;
    logic        ctlWr;
    // the master drops address and data once taken, so keep our own copy
    assign ctlWr = awCap == charge_time_pkg::OffControl && sCap == 4'hf;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awCap <= 8'h00;
            arCap <= 8'h00;
            wCap <= 32'h00000000;
            sCap <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) awCap <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) arCap <= s_axi_araddr;
            if (s_axi_wvalid && s_axi_wready) {wCap, sCap} <= {s_axi_wdata, s_axi_wstrb};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_trim_copy: assert property ($rose(s_axi_bvalid) && ctlWr |=> currentTrim == wCap[7:2])
        else $error("trim output differs from written field");
    a_range_copy: assert property ($rose(s_axi_bvalid) && ctlWr |=> currentRange == wCap[1:0])
        else $error("range output differs from written field");
    a_ground_copy: assert property ($rose(s_axi_bvalid) && ctlWr |=> sourceGround == wCap[9])
        else $error("ground switch differs from written bit");
    a_unit_enable: assert property ($rose(s_axi_bvalid) && ctlWr |=>
        unitActive == (wCap[15] && !(wCap[13] && $past(idleMode))))
        else $error("unit active does not follow enable and idle stop");
    a_delay_gen: assert property (delayGenActive |-> unitActive)
        else $error("delay generation active while unit stopped");
    a_alias_okay: assert property ($rose(s_axi_bvalid) && awCap < 8'h10 && awCap[1:0] == 2'b00 |->
        s_axi_bresp == charge_time_pkg::RespOkay)
        else $error("write to control word or alias refused");
    a_unmapped_err: assert property ($rose(s_axi_bvalid) && awCap > 8'h10 |->
        s_axi_bresp == charge_time_pkg::RespSlvErr)
        else $error("unmapped write not refused");
    a_read_zero: assert property (s_axi_rvalid && arCap < 8'h10 |->
        s_axi_rdata[17:16] == 2'b00 && !s_axi_rdata[14])
        else $error("unimplemented bits read nonzero");
    a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");

    c_trigger: cover property ($rose(triggerOut));
    c_unit_on: cover property ($rose(unitActive));
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == charge_time_pkg::RespSlvErr);
endmodule

/* File: charge_time_edge_control_tb.sv */
/*
 charge_time_edge_control_tb: random and directed test of control word, aliases, bus
 errors, analog outputs, idle stop and edge flags of every source code.
 assumes: package, interface and design compiled first; checker bound at the foot.
*/
`timescale 1ns/1ps
module charge_time_edge_control_tb;
    logic clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, compareEvent1 = 1'b0, timer1Event = 1'b0, idleMode = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd, exp, m;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [3:1] comparatorOut = 3'h0, captureEvent = 3'h0;
    logic [13:1] edgePin = 13'h0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic unitActive, delayGenActive, sourceGround, triggerOut;
    logic [1:0] s_axi_bresp, s_axi_rresp, currentRange, rsp;
    logic [5:0] currentTrim;
    int error_cnt = 0, tests_run = 0, trigCnt = 0, seed = 32'h87488d68;

    always #2 clk = ~clk;
    always @(posedge clk) if (triggerOut === 1'b1) trigCnt++;

    charge_time_edge_control #(.PinCount(13)) u_dut (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .comparatorOut(comparatorOut),
        .edgePin(edgePin), .captureEvent(captureEvent), .compareEvent1(compareEvent1),
        .timer1Event(timer1Event), .idleMode(idleMode), .unitActive(unitActive),
        .delayGenActive(delayGenActive), .sourceGround(sourceGround), .triggerOut(triggerOut),
        .currentTrim(currentTrim), .currentRange(currentRange));

    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chkWord(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkResp(input string n, input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // handshakes are judged at the falling edge, where the combinational readies are settled
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic aw, w, b;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge clk);
            {aw, w, b, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            n++;
        end while (b !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40) begin
            chkWord("write handshake", 32'h1, 32'h0);
            conclude();
        end
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic ar, v;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(negedge clk);
            {ar, v, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            n++;
        end while (v !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        if (n >= 40) begin
            chkWord("read handshake", 32'h1, 32'h0);
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axiWrite(a, d, rsp);
        chkResp("bresp", charge_time_pkg::RespOkay, rsp);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
        axiRead(a, rd, rsp);
        chkWord(n, e, rd);
    endtask

    // other channel watches a rising edge on a source the case leaves alone
    function automatic logic [31:0] cfg(input int ch, input int k, input logic [1:0] mp);
        logic [31:0] v;
        logic [5:0]  o;
        o = {2'b11, k == 1 ? 4'h0 : 4'h1};
        v = {o, 2'b00, o, 18'h08901};
        if (ch == 1) v[31:26] = {mp, 4'(k)};
        else v[23:18] = {mp, 4'(k)};
        return v;
    endfunction

    task automatic setSrc(input int ch, input int k, input logic v);
        if (k >= 13) comparatorOut[k - 12] <= v;
        else if (k >= 11 - ch && k <= 13 - ch) captureEvent[k - 10 + ch] <= v;
        else if (k >= 4 && k < 11 - ch) edgePin[ch == 1 ? k - 1 : k + 5] <= v;
        else if (k == 3) edgePin[1] <= v;
        else if (k == 2) edgePin[2] <= v;
        else if (k == 1) compareEvent1 <= v;
        else if (k == 0) timer1Event <= v;
    endtask

    task automatic edgeCase(input int ch, input int k);
        wr(8'h00, cfg(ch, k, 2'b11));
        repeat (6) @(posedge clk);
        wr(8'h04, 32'h03000000);
        if (!(ch == 2 && k == 12)) rdChk(8'h00, cfg(ch, k, 2'b11), "flag quiet");
        setSrc(ch, k, 1'b1);
        repeat (6) @(posedge clk);
        rdChk(8'h00, cfg(ch, k, 2'b11) | (32'h1 << (23 + ch)), "flag seen");
        setSrc(ch, k, 1'b0);
    endtask

    task automatic pulse(input int ch, input int k);
        setSrc(ch, k, 1'b1);
        @(posedge clk);
        setSrc(ch, k, 1'b0);
        repeat (6) @(posedge clk);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdChk(8'h00, charge_time_pkg::ControlReset, "reset word");
        chkWord("reset outputs", 32'h0, {unitActive, delayGenActive, sourceGround, triggerOut, currentTrim, currentRange});
        for (int i = 0; i < 8; i++) begin
            m = $random(seed) & ~32'h00009000;
            wr(8'h00, m);
            rdChk(8'h00, m & charge_time_pkg::ImplMask, "readback");
            chkWord("outputs", {23'h0, m[9], m[7:0]}, {22'h0, unitActive, sourceGround, currentTrim, currentRange});
        end
        exp = m & charge_time_pkg::ImplMask;
        for (int i = 0; i < 9; i++) begin
            m = $random(seed) & ~32'h00009000;
            wr(8'(4 * (i % 3 + 1)), m);
            exp = (i % 3 == 0 ? exp & ~m : i % 3 == 1 ? exp | m : exp ^ m) & charge_time_pkg::ImplMask;
            rdChk(8'(4 * (i % 3 + 1)), exp, "alias");
        end
        axiWrite(8'h14, 32'hffffffff, rsp);
        chkResp("unmapped write", charge_time_pkg::RespSlvErr, rsp);
        axiRead(8'h14, rd, rsp);
        chkResp("unmapped read", charge_time_pkg::RespSlvErr, rsp);
        rdChk(8'h00, exp, "after unmapped");
        for (int i = 0; i < 4; i++) begin
            idleMode <= i[0];
            wr(8'h00, i[1] ? 32'h0038b000 : 32'h00389000);
            repeat (3) @(posedge clk);
            chkWord("unit", {31'h0, ~(i[1] & i[0])}, {31'h0, unitActive});
            chkWord("delay", {31'h0, ~(i[1] & i[0])}, {31'h0, delayGenActive});
        end
        idleMode <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            edgeCase(1, k);
            edgeCase(2, k);
        end
        for (int ch = 1; ch < 3; ch++) begin
            wr(8'h00, cfg(ch, 0, 2'b00) | 32'h00000200);
            repeat (3) @(posedge clk);
            wr(8'h04, 32'h03000200);
            repeat (3) @(posedge clk);
            rdChk(8'h00, cfg(ch, 0, 2'b00) | (32'h1 << (23 + ch)), "level low");
        end
        m = cfg(1, 0, 2'b11) & ~32'h00000800;
        wr(8'h00, m);
        wr(8'h04, 32'h03000000);
        pulse(1, 0);
        rdChk(8'h00, m, "blocked");
        m = cfg(2, 1, 2'b11) | 32'h00000400;
        wr(8'h00, m);
        trigCnt = 0;
        pulse(2, 1);
        rdChk(8'h00, m, "order early");
        pulse(1, 0);
        pulse(2, 1);
        rdChk(8'h00, m | 32'h03000000, "order kept");
        chkWord("trigger", 32'h1, 32'(trigCnt));
        conclude();
    end
endmodule

bind charge_time_edge_control charge_time_edge_control_properties #(.PinCount(PinCount)) u_props (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .idleMode(idleMode), .unitActive(unitActive),
    .delayGenActive(delayGenActive), .sourceGround(sourceGround), .triggerOut(triggerOut),
    .currentTrim(currentTrim), .currentRange(currentRange));
